// *** src/plfc_pkg.sv ***
// Package of constants and types for the program line flow control block
// Overview of operation
// RQ1 - Iterate-if-negative returns to step one when accumulator below zero, else continues.
// RQ2 - Iterate-if-nonnegative returns to step one when accumulator zero or above.
// RQ3 - Conditional iterate repeats while condition holds, then rest of line runs.
// RQ4 - Jumps act at once: end line, transfer selector two, start chosen line.
// RQ5 - Unconditional jump must be wired as the last step of its line.
// RQ6 - Unconditional jump chains at most two program lines together; the code sets no limit, a jumped-to line can jump again.
// RQ7 - Jump-if-negative at any step starts selected line when accumulator negative.
// RQ8 - Jump-if-nonnegative at any step starts selected line when accumulator not negative.
// RQ9 - Unmet conditional jump has no effect; rest of line executes.
// RQ10 - Selector two returns to normal when the jumped-to line finishes.
// RQ11 - Reader switch hands control to auxiliary reader; punches 2-3-5 in non-print.
// RQ12 - Read start reads on own reader, switching back; punches 2-3-4 in non-print.
// RQ13 - Skip tab command arms skip tab; punches 2-4-6 in non-print.
// RQ14 - Tape skip passes all codes until skip restore; punches 2-4-7 in non-print.
// RQ15 - Combined non-print and tape skip ends only on print restore.
// RQ16 - Field control on enters field punch control if switch at select; punches 2-3-4-5-7.
// RQ17 - Field control overrides key lever control; lever punches stay on.
// RQ18 - Stop halts all reading; punches 1-2-4 in non-print; print restore should follow.
// RQ19 - Functional codes seven to sixteen perform no function.
// RQ20 - Code seventeen locks keyboard where fitted; eighteen unlocks it.
// RQ21 - Tape control command must be last step, after enabling reader.
// RQ22 - Field program control command must be last step, before start actuator.
// RQ23 - Unconditional iterate returns to step one; must be last instruction.
// RQ24 - Print restore ends non-print and resumes printing, punching nothing.
// RQ25 - Steps run in order, each finishing its typewriter command first.
package plfc_pkg;

  localparam int OP_W = 5;
  localparam int ADDR_W = 5;
  localparam int STEP_W = 6;
  localparam int LINE_W = 6;

  // Operation codes
  localparam logic [OP_W-1:0] OP_OUTPUT = 5'h09;
  localparam logic [OP_W-1:0] OP_CTRL = 5'h0a;
  localparam logic [OP_W-1:0] OP_FUNC = 5'h0b;

  // Control addresses
  localparam logic [ADDR_W-1:0] A_ITER = 5'h06;
  localparam logic [ADDR_W-1:0] A_ITER_NEG = 5'h07;
  localparam logic [ADDR_W-1:0] A_ITER_POS = 5'h08;
  localparam logic [ADDR_W-1:0] A_JUMP = 5'h09;
  localparam logic [ADDR_W-1:0] A_JUMP_NEG = 5'h0a;
  localparam logic [ADDR_W-1:0] A_JUMP_POS = 5'h0b;

  // Output addresses
  localparam logic [ADDR_W-1:0] A_PRINT_RESTORE = 5'h13;
  localparam logic [ADDR_W-1:0] A_NON_PRINT = 5'h14;
  localparam logic [ADDR_W-1:0] A_PUNCH_ON = 5'h0a;
  localparam logic [ADDR_W-1:0] A_PUNCH_OFF = 5'h0b;

  // Functional addresses
  localparam logic [ADDR_W-1:0] F_AUX_READER = 5'h01;
  localparam logic [ADDR_W-1:0] F_READ_START = 5'h02;
  localparam logic [ADDR_W-1:0] F_SKIP_TAB = 5'h03;
  localparam logic [ADDR_W-1:0] F_TAPE_SKIP = 5'h04;
  localparam logic [ADDR_W-1:0] F_FIELD_ON = 5'h05;
  localparam logic [ADDR_W-1:0] F_STOP = 5'h06;
  localparam logic [ADDR_W-1:0] F_KB_LOCK = 5'h11;
  localparam logic [ADDR_W-1:0] F_KB_UNLOCK = 5'h12;
  localparam logic [ADDR_W-1:0] F_TAPE_CTRL = 5'h13;
  localparam logic [ADDR_W-1:0] F_FIELD_CTRL = 5'h14;

  // Tape channel codes, bit n-1 is channel n
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_AUX_READER = 8'h16;
  localparam logic [7:0] CODE_SWITCH = 8'h0e;
  localparam logic [7:0] CODE_SKIP_TAB = 8'h2a;
  localparam logic [7:0] CODE_TAPE_SKIP = 8'h4a;
  localparam logic [7:0] CODE_FIELD_ON = 8'h5e;
  localparam logic [7:0] CODE_STOP = 8'h0b;

  // Register reset values and APB map
  localparam logic [LINE_W-1:0] LINE_RST = 6'h00;
  localparam logic [STEP_W-1:0] STEP_FIRST = 6'h00;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_INSTR = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_LINES = 12'h00c;
  localparam logic [11:0] REG_CODE = 12'h010;

  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [ADDR_W-1:0] addr;
  } plfc_instr_t;

  typedef struct packed {
    logic aux_reader;
    logic reading;
    logic skip_tab;
    logic tape_skip;
    logic non_print;
    logic punch_on;
    logic field_punch_control_on;
    logic kb_locked;
    logic tape_prog;
    logic sel2;
  } plfc_state_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_WAIT = 2'b10
  } plfc_fsm_t;

endpackage : plfc_pkg

// *** src/plfc_typer_cmd.sv ***
// Typewriter command handshake: one command out, waits for done
`timescale 1ns/100ps
module plfc_typer_cmd
  import plfc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from sequencer
  input wire logic start,
  input wire logic [7:0] code_in,
  output logic busy,
  output logic done,
  // Typewriter side
  input wire logic ack_async,
  output logic cmd_valid_r,
  output logic [7:0] cmd_code_r
);
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_prev_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_async;
      ack_s2_r <= ack_s1_r;
      ack_prev_r <= ack_s2_r;
    end
  end

  assign done = cmd_valid_r && ack_s2_r && !ack_prev_r;
  assign busy = cmd_valid_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid_r <= 1'b0;
      cmd_code_r <= CODE_NONE;
    end else if (start && !cmd_valid_r) begin
      cmd_valid_r <= 1'b1;
      cmd_code_r <= code_in;
    end else if (done) begin
      cmd_valid_r <= 1'b0;
    end
  end

endmodule : plfc_typer_cmd

// *** src/plfc_top.sv ***
// Program line flow control: sequencer, decoder, APB registers
`timescale 1ns/100ps
module plfc_top
  import plfc_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Typewriter pins
  input wire logic typer_ack,
  input wire logic punch_select_sw,
  input wire logic print_restore_code,
  input wire logic skip_restore_code,
  output logic typer_cmd_valid,
  output logic [7:0] typer_cmd_code,
  output plfc_state_t typer_state,
  // Program line status
  output logic [LINE_W-1:0] line_r,
  output logic [STEP_W-1:0] step_r
);
  plfc_fsm_t fsm_r;
  plfc_fsm_t fsm_nxt;
  plfc_state_t st;
  plfc_instr_t instr_r;
  logic run_r;
  logic acc_neg_r;
  logic instr_valid_r;
  logic [LINE_W-1:0] alt_line_r;
  logic jumped_r;
  logic last_step_r;
  logic sw_s1_r;
  logic sw_s2_r;
  logic pr_s1_r;
  logic pr_s2_r;
  logic sk_s1_r;
  logic sk_s2_r;
  logic [7:0] last_code_r;
  logic wr_en;
  logic rd_en;
  logic step_go;
  logic line_end;
  logic do_iter;
  logic do_jump;
  logic is_ctrl;
  logic is_func;
  logic is_out;
  logic punch_ok;
  logic [7:0] code;
  logic cmd_start;
  logic cmd_busy;
  logic cmd_done;
  logic out_go;
  logic func_go;
  logic aux_reader_r;
  logic reading_r;
  logic skip_tab_r;
  logic tape_skip_r;
  logic non_print_r;
  logic punch_on_r;
  logic field_punch_control_on_r;
  logic kb_locked_r;
  logic tape_prog_r;
  logic sel2_r;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_s1_r <= 1'b0;
      sw_s2_r <= 1'b0;
      pr_s1_r <= 1'b0;
      pr_s2_r <= 1'b0;
      sk_s1_r <= 1'b0;
      sk_s2_r <= 1'b0;
    end else begin
      sw_s1_r <= punch_select_sw;
      sw_s2_r <= sw_s1_r;
      pr_s1_r <= print_restore_code;
      pr_s2_r <= pr_s1_r;
      sk_s1_r <= skip_restore_code;
      sk_s2_r <= sk_s1_r;
    end
  end

  // Instruction word from software, one per step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r <= '0;
      acc_neg_r <= 1'b0;
      last_step_r <= 1'b0;
      instr_valid_r <= 1'b0;
    end else if (wr_en && paddr == REG_INSTR && !instr_valid_r) begin
      instr_r <= pwdata[OP_W+ADDR_W-1:0];
      acc_neg_r <= pwdata[16];
      last_step_r <= pwdata[17];
      instr_valid_r <= 1'b1;
    end else if (step_go) begin
      instr_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      alt_line_r <= LINE_RST;
    end else if (wr_en && paddr == REG_CTRL) begin
      run_r <= pwdata[0];
      alt_line_r <= pwdata[8 +: LINE_W];
    end
  end

  // Decode
  assign is_ctrl = instr_r.op == OP_CTRL;
  assign is_func = instr_r.op == OP_FUNC;
  assign is_out = instr_r.op == OP_OUTPUT;
  assign do_iter = is_ctrl && (instr_r.addr == A_ITER //RQ23
    || (instr_r.addr == A_ITER_NEG && acc_neg_r) //RQ1
    || (instr_r.addr == A_ITER_POS && !acc_neg_r)); //RQ2
  assign do_jump = is_ctrl && (instr_r.addr == A_JUMP //RQ4
    || (instr_r.addr == A_JUMP_NEG && acc_neg_r) //RQ7
    || (instr_r.addr == A_JUMP_POS && !acc_neg_r)); //RQ8
  assign punch_ok = punch_on_r && non_print_r;

  always_comb begin
    code = CODE_NONE;
    if (is_func && punch_ok) begin
      case (instr_r.addr)
        F_AUX_READER: code = CODE_AUX_READER; //RQ11
        F_READ_START: code = CODE_SWITCH; //RQ12
        F_SKIP_TAB: code = CODE_SKIP_TAB; //RQ13
        F_TAPE_SKIP: code = CODE_TAPE_SKIP; //RQ14
        F_FIELD_ON: code = CODE_FIELD_ON; //RQ16
        F_STOP: code = CODE_STOP; //RQ18
        default: code = CODE_NONE; //RQ19
      endcase
    end
  end

  // Sequencer
  always_comb begin
    fsm_nxt = fsm_r;
    cmd_start = 1'b0;
    step_go = 1'b0;
    case (fsm_r)
      ST_IDLE: if (run_r && instr_valid_r) fsm_nxt = ST_DECODE;
      ST_DECODE: begin
        cmd_start = 1'b1;
        fsm_nxt = ST_WAIT;
      end
      ST_WAIT: if (cmd_done) begin
        step_go = 1'b1; //RQ25
        fsm_nxt = ST_IDLE;
      end
      default: fsm_nxt = ST_IDLE;
    endcase
  end

  assign line_end = step_go && (do_iter || do_jump || last_step_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fsm_r <= ST_IDLE;
    else fsm_r <= fsm_nxt;
  end

  // Step and line tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_r <= STEP_FIRST;
      line_r <= LINE_RST;
      jumped_r <= 1'b0;
    end else if (step_go) begin
      if (do_iter) begin
        step_r <= STEP_FIRST; //RQ3
      end else if (do_jump) begin
        step_r <= STEP_FIRST; //RQ4
        line_r <= alt_line_r;
        jumped_r <= 1'b1;
      end else if (last_step_r) begin
        step_r <= STEP_FIRST;
        jumped_r <= 1'b0; //RQ10
      end else begin
        step_r <= step_r + 6'h01; //RQ9
      end
    end
  end

  // Typewriter state, one flag per process
  assign out_go = step_go && is_out;
  assign func_go = step_go && is_func;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sel2_r <= 1'b0;
    else if (step_go && do_jump) sel2_r <= 1'b1; //RQ4
    else if (line_end && !do_iter && jumped_r) sel2_r <= 1'b0; //RQ10
  end

  // Set wins over a restore in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) non_print_r <= 1'b0;
    else if (out_go && instr_r.addr == A_NON_PRINT) non_print_r <= 1'b1;
    else if (out_go && instr_r.addr == A_PRINT_RESTORE) non_print_r <= 1'b0; //RQ24
    else if (pr_s2_r) non_print_r <= 1'b0; //RQ15
  end

  // Tape skip, ended by print restore, or by skip restore only outside non-print
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tape_skip_r <= 1'b0;
    else if (func_go && instr_r.addr == F_TAPE_SKIP) tape_skip_r <= 1'b1; //RQ14
    else if (out_go && instr_r.addr == A_PRINT_RESTORE) tape_skip_r <= 1'b0; //RQ15
    else if (pr_s2_r) tape_skip_r <= 1'b0; //RQ15
    else if (sk_s2_r && !non_print_r) tape_skip_r <= 1'b0; //RQ14
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) punch_on_r <= 1'b0;
    else if (out_go && instr_r.addr == A_PUNCH_ON) punch_on_r <= 1'b1;
    else if (out_go && instr_r.addr == A_PUNCH_OFF) punch_on_r <= 1'b0;
  end

  // Reader selection and reading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) aux_reader_r <= 1'b0;
    else if (func_go && instr_r.addr == F_AUX_READER) aux_reader_r <= 1'b1; //RQ11
    else if (func_go && instr_r.addr == F_READ_START) aux_reader_r <= 1'b0; //RQ12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) reading_r <= 1'b0;
    else if (func_go && instr_r.addr == F_READ_START) reading_r <= 1'b1; //RQ12
    else if (func_go && instr_r.addr == F_STOP) reading_r <= 1'b0; //RQ18
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) skip_tab_r <= 1'b0;
    else if (func_go && instr_r.addr == F_SKIP_TAB) skip_tab_r <= 1'b1; //RQ13
  end

  // Lever punches untouched when field control starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_punch_control_on_r <= 1'b0;
    end else if (func_go && instr_r.addr == F_FIELD_ON && sw_s2_r) begin
      field_punch_control_on_r <= 1'b1; //RQ16 RQ17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) kb_locked_r <= 1'b0;
    else if (func_go && instr_r.addr == F_KB_LOCK) kb_locked_r <= 1'b1; //RQ20
    else if (func_go && instr_r.addr == F_KB_UNLOCK) kb_locked_r <= 1'b0; //RQ20
  end

  // Program control source: tape or carriage actuators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tape_prog_r <= 1'b0;
    else if (func_go && instr_r.addr == F_TAPE_CTRL) tape_prog_r <= 1'b1;
    else if (func_go && instr_r.addr == F_FIELD_CTRL) tape_prog_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_code_r <= CODE_NONE;
    else if (cmd_start) last_code_r <= code;
  end

  assign st = {aux_reader_r, reading_r, skip_tab_r, tape_skip_r, non_print_r, punch_on_r,
    field_punch_control_on_r, kb_locked_r, tape_prog_r, sel2_r};
  assign typer_state = st;

  plfc_typer_cmd u_cmd (
    .pclk(pclk),
    .presetn(presetn),
    .start(cmd_start),
    .code_in(code),
    .busy(cmd_busy),
    .done(cmd_done),
    .ack_async(typer_ack),
    .cmd_valid_r(typer_cmd_valid),
    .cmd_code_r(typer_cmd_code)
  );

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      case (paddr)
        REG_CTRL: prdata <= {16'h0, 2'h0, alt_line_r, 7'h0, run_r};
        REG_INSTR: prdata <= {14'h0, last_step_r, acc_neg_r, 5'h0, instr_valid_r,
                              instr_r};
        REG_STATUS: prdata <= {20'h0, cmd_busy, fsm_r != ST_IDLE, st};
        REG_LINES: prdata <= {16'h0, 2'h0, line_r, 2'h0, step_r};
        REG_CODE: prdata <= {24'h0, last_code_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

endmodule : plfc_top

// *** tb/plfc_asserts.sv ***
// Concurrent checks on the program line flow control ports
`timescale 1ns/100ps
module plfc_asserts
  import plfc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Typewriter pins
  input wire logic typer_ack,
  input wire logic typer_cmd_valid,
  input wire logic [7:0] typer_cmd_code,
  input wire plfc_state_t typer_state,
  // Line status
  input wire logic [LINE_W-1:0] line_r,
  input wire logic [STEP_W-1:0] step_r
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cmd_holds: assert property (typer_cmd_valid && !typer_ack |=> typer_cmd_valid)
    else $error("command dropped before ack");
  a_code_steady: assert property (typer_cmd_valid && $past(typer_cmd_valid)
    |-> $stable(typer_cmd_code))
    else $error("command code changed while pending");
  a_step_frozen: assert property (typer_cmd_valid && $past(typer_cmd_valid)
    |-> $stable(step_r) && $stable(line_r))
    else $error("step moved while command pending");
  a_done_after_ack: assert property ($fell(typer_cmd_valid) |-> $past(typer_ack, 2))
    else $error("command ended without ack");
  a_print_no_punch: assert property ($rose(typer_cmd_valid) && !typer_state.non_print
    |-> typer_cmd_code == CODE_NONE)
    else $error("code punched while printing");
  a_read_own: assert property ($rose(typer_state.reading) |-> !typer_state.aux_reader)
    else $error("read started on auxiliary reader");
  a_jump_first: assert property ($rose(typer_state.sel2) |-> step_r == STEP_FIRST)
    else $error("jump did not restart at first step");
  a_sel2_end: assert property ($fell(typer_state.sel2) |-> step_r == STEP_FIRST)
    else $error("selector two reset inside a line");
  a_step_next: assert property ($fell(typer_cmd_valid) && step_r != STEP_FIRST
    |-> step_r - $past(step_r) == 6'h01)
    else $error("step did not advance by one");
endmodule : plfc_asserts

bind plfc_top plfc_asserts u_chk (.pclk(pclk), .presetn(presetn), .typer_ack(typer_ack),
  .typer_cmd_valid(typer_cmd_valid), .typer_cmd_code(typer_cmd_code),
  .typer_state(typer_state), .line_r(line_r), .step_r(step_r));

// *** tb/plfc_typer_model.sv ***
// Typewriter model answering each command after a set delay
`timescale 1ns/100ps
module plfc_typer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command handshake
  input wire logic cmd_valid,
  input wire logic [3:0] dly,
  output logic ack
);
  logic [3:0] cnt_r;

  // Ack held until the command drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      ack <= 1'b0;
    end else if (!cmd_valid) begin
      cnt_r <= 4'h0;
      ack <= 1'b0;
    end else if (cnt_r >= dly) begin
      ack <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : plfc_typer_model

// *** tb/testbench.sv ***
// Self-checking testbench for the program line flow control block
`timescale 1ns/100ps
module testbench
  import plfc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic ack, sw, prc, src, cv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] cc, code;
  logic [3:0] dly;
  logic [LINE_W-1:0] line;
  logic [STEP_W-1:0] step;
  plfc_state_t st;
  int err_count, check_count, cyc;

  plfc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .typer_ack(ack), .punch_select_sw(sw), .print_restore_code(prc),
    .skip_restore_code(src), .typer_cmd_valid(cv), .typer_cmd_code(cc),
    .typer_state(st), .line_r(line), .step_r(step));
  plfc_typer_model tw (.pclk(pclk), .presetn(presetn), .cmd_valid(cv), .dly(dly), .ack(ack));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Last code offered to the typewriter
  always @(posedge pclk) begin
    if (cv === 1'b1) code <= cc;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task report(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : report

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    report({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task chk_step(input logic [STEP_W-1:0] exp);
    report({26'h0, step}, {26'h0, exp});
  endtask : chk_step

  task chk_line(input logic [LINE_W-1:0] exp);
    report({26'h0, line}, {26'h0, exp});
  endtask : chk_line

  task chk_code(input logic [7:0] exp);
    report({24'h0, code}, {24'h0, exp});
  endtask : chk_code

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One step, then poll until it is retired
  task exec(input logic [OP_W-1:0] o, input logic [ADDR_W-1:0] a, input logic n,
    input logic l);
    apb(1'b1, REG_INSTR, {14'h0, l, n, 6'h0, o, a});
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, REG_INSTR, 32'h0);
      if (rd[10] === 1'b0) break;
    end
    chk_bit(rd[10], 1'b0);
  endtask : exec

  task xs(input logic [OP_W-1:0] o, input logic [ADDR_W-1:0] a, input logic n,
    input logic l, input logic [STEP_W-1:0] e);
    exec(o, a, n, l);
    chk_step(e);
  endtask : xs

  task fn(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    exec(OP_FUNC, a, 1'b0, 1'b0);
    chk_code(e);
  endtask : fn

  task t_iter;
    xs(OP_OUTPUT, 5'h08, 1'b0, 1'b0, 6'h01);
    xs(OP_CTRL, A_ITER_NEG, 1'b1, 1'b0, 6'h00);
    xs(OP_OUTPUT, 5'h08, 1'b0, 1'b0, 6'h01);
    xs(OP_CTRL, A_ITER_NEG, 1'b0, 1'b0, 6'h02);
    xs(OP_CTRL, A_ITER_POS, 1'b1, 1'b0, 6'h03);
    xs(OP_CTRL, A_ITER_POS, 1'b0, 1'b0, 6'h00);
    xs(OP_OUTPUT, 5'h08, 1'b0, 1'b0, 6'h01);
    xs(OP_CTRL, A_ITER, 1'b0, 1'b1, 6'h00);
    $display("t_iter done");
  endtask : t_iter

  task t_jump;
    xs(OP_CTRL, A_JUMP_NEG, 1'b0, 1'b0, 6'h01);
    chk_bit(st.sel2, 1'b0);
    xs(OP_CTRL, A_JUMP_POS, 1'b1, 1'b0, 6'h02);
    xs(OP_CTRL, A_JUMP_NEG, 1'b1, 1'b0, 6'h00);
    chk_line(6'h05);
    chk_bit(st.sel2, 1'b1);
    exec(OP_OUTPUT, 5'h08, 1'b0, 1'b1);
    chk_bit(st.sel2, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0901);
    xs(OP_CTRL, A_JUMP_POS, 1'b0, 1'b0, 6'h00);
    chk_line(6'h09);
    apb(1'b0, REG_LINES, 32'h0);
    chk_word(rd, 32'h0900);
    exec(OP_OUTPUT, 5'h08, 1'b0, 1'b0);
    xs(OP_CTRL, A_JUMP, 1'b0, 1'b1, 6'h00);
    chk_line(6'h09);
    $display("t_jump done");
  endtask : t_jump

  task t_func;
    sw <= 1'b1;
    exec(OP_OUTPUT, A_PUNCH_ON, 1'b0, 1'b0);
    exec(OP_OUTPUT, A_NON_PRINT, 1'b0, 1'b0);
    fn(F_AUX_READER, CODE_AUX_READER);
    chk_bit(st.aux_reader, 1'b1);
    fn(F_READ_START, CODE_SWITCH);
    chk_bit(st.aux_reader, 1'b0);
    chk_bit(st.reading, 1'b1);
    fn(F_SKIP_TAB, CODE_SKIP_TAB);
    chk_bit(st.skip_tab, 1'b1);
    fn(F_TAPE_SKIP, CODE_TAPE_SKIP);
    chk_bit(st.tape_skip, 1'b1);
    fn(F_FIELD_ON, CODE_FIELD_ON);
    chk_bit(st.field_punch_control_on, 1'b1);
    chk_bit(st.punch_on, 1'b1);
    fn(F_STOP, CODE_STOP);
    chk_bit(st.reading, 1'b0);
    apb(1'b0, REG_CODE, 32'h0);
    chk_word(rd, {24'h0, CODE_STOP});
    exec(OP_OUTPUT, A_PRINT_RESTORE, 1'b0, 1'b0);
    chk_code(CODE_NONE);
    chk_bit(st.non_print, 1'b0);
    fn(F_AUX_READER, CODE_NONE);
    $display("t_func done");
  endtask : t_func

  task t_skip;
    exec(OP_OUTPUT, A_NON_PRINT, 1'b0, 1'b0);
    fn(F_TAPE_SKIP, CODE_TAPE_SKIP);
    src <= 1'b1;
    repeat (6) @(posedge pclk);
    chk_bit(st.tape_skip, 1'b1);
    src <= 1'b0;
    prc <= 1'b1;
    repeat (6) @(posedge pclk);
    chk_bit(st.tape_skip, 1'b0);
    chk_bit(st.non_print, 1'b0);
    prc <= 1'b0;
    fn(F_TAPE_SKIP, CODE_NONE);
    chk_bit(st.tape_skip, 1'b1);
    src <= 1'b1;
    repeat (6) @(posedge pclk);
    chk_bit(st.tape_skip, 1'b0);
    src <= 1'b0;
    $display("t_skip done");
  endtask : t_skip

  task t_kb;
    plfc_state_t sv;
    exec(OP_FUNC, F_KB_LOCK, 1'b0, 1'b0);
    chk_bit(st.kb_locked, 1'b1);
    sv = st;
    for (int a = 7; a <= 16; a++) begin
      exec(OP_FUNC, 5'(a), 1'b0, 1'b0);
      chk_word({22'h0, st}, {22'h0, sv});
    end
    exec(OP_FUNC, F_KB_UNLOCK, 1'b0, 1'b0);
    chk_bit(st.kb_locked, 1'b0);
    exec(OP_FUNC, F_READ_START, 1'b0, 1'b0);
    exec(OP_FUNC, F_TAPE_CTRL, 1'b0, 1'b1);
    chk_bit(st.tape_prog, 1'b1);
    chk_bit(st.sel2, 1'b0);
    exec(OP_FUNC, F_FIELD_CTRL, 1'b0, 1'b1);
    chk_bit(st.tape_prog, 1'b0);
    apb(1'b1, 12'h100, 32'hffffffff);
    apb(1'b0, 12'h100, 32'h0);
    chk_word(rd, 32'h0);
    chk_bit(pslverr, 1'b0);
    $display("t_kb done");
  endtask : t_kb

  task t_reset;
    presetn <= 1'b0;
    sw <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_word({22'h0, st}, 32'h0);
    chk_step(STEP_FIRST);
    chk_line(LINE_RST);
    apb(1'b1, REG_CTRL, 32'h0001);
    exec(OP_OUTPUT, A_PUNCH_ON, 1'b0, 1'b0);
    fn(F_FIELD_ON, CODE_NONE);
    chk_bit(st.field_punch_control_on, 1'b0);
    $display("t_reset done");
  endtask : t_reset

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sw, prc, src} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    dly = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, REG_CTRL, 32'h0501);
    t_iter();
    t_jump();
    dly <= 4'h6;
    t_func();
    t_skip();
    t_kb();
    t_reset();
    end_of_test();
  end
endmodule : testbench
